// ===== core/gbcd_cmd_if.sv
`timescale 1ns/10ps
interface gbcd_cmd_if;
  import gbcd_pkg::*;
  gbcd_byte_t cmd_byte;
  gbcd_addr_t own_addr;
  gbcd_cmd_e  cmd;
  modport dec  (input cmd_byte, input own_addr, output cmd);
  modport user (output cmd_byte, output own_addr, input cmd);
endinterface : gbcd_cmd_if

// ===== core/gbcd_decode.sv
`timescale 1ns/10ps
`include "gbcd_defines.svh"
module gbcd_decode
  import gbcd_pkg::*;
(
  gbcd_cmd_if.dec bus
);

  // Builds the listen or talk byte of a primary address.
  function automatic gbcd_byte_t addr_byte(input gbcd_byte_t base, input gbcd_addr_t pa);
    addr_byte = base | {3'h0, pa};
  endfunction : addr_byte

  gbcd_byte_t b;

  // Bit 7 is not part of a command, so it is masked before any compare.
  always_comb begin
    b = bus.cmd_byte & `GBCD_BYTE_MASK;
    // Unaddress codes are tested first so that address 31 never claims them.
    case (b)
      `GBCD_CODE_GTL: bus.cmd = CMD_GTL;
      `GBCD_CODE_SDC: bus.cmd = CMD_SDC;
      `GBCD_CODE_GET: bus.cmd = CMD_GET;
      `GBCD_CODE_LLO: bus.cmd = CMD_LLO;
      `GBCD_CODE_DCL: bus.cmd = CMD_DCL;
      `GBCD_CODE_SPE: bus.cmd = CMD_SPE;
      `GBCD_CODE_SPD: bus.cmd = CMD_SPD;
      `GBCD_CODE_UNL: bus.cmd = CMD_UNL;
      `GBCD_CODE_UNT: bus.cmd = CMD_UNT;
      default: begin
        if (b == addr_byte(`GBCD_LAG_BASE, bus.own_addr)) begin
          bus.cmd = CMD_MLA;
        end else if (b == addr_byte(`GBCD_TAG_BASE, bus.own_addr)) begin
          bus.cmd = CMD_MTA;
        end else if ((b & `GBCD_GROUP_MASK) == `GBCD_TAG_BASE) begin
          bus.cmd = CMD_OTA;
        end else if ((b & `GBCD_GROUP_MASK) == `GBCD_SCG_BASE) begin
          bus.cmd = CMD_SCG;
        end else begin
          bus.cmd = CMD_NONE;
        end
      end
    endcase
  end

endmodule : gbcd_decode

// ===== core/gbcd_defines.svh
// Contract
// - Bytes taken while ATN is low are commands or addresses, never data.
// - Bytes taken while ATN is high go to the message parser as data.
// - Service request stays asserted from the need until service is handled; the code also drops it on a device clear.
// - Remote enable moves the device to remote; panel lock may follow it.
// - EOI marks the last byte of a transfer, whatever its length.
// - Interface clear forces talker idle and listener idle.
// - Local lockout disables the local key and all panel controls.
// - Universal commands act whether or not the device is addressed.
// - Device clear returns the device to its power-up defaults.
// - Serial poll enable enters serial poll mode.
// - Serial poll disable leaves serial poll mode.
// - Addressed commands act only on a device already listen-addressed; with GET_UNADDR_I set, GET acts unaddressed too.
// - Selective device clear acts like device clear, only when listen-addressed.
// - Go to local leaves remote when listen-addressed; may release lockout.
// - Group execute trigger starts the trigger action, optionally unaddressed.
// - Own primary address ORed with 20h makes the device a listener.
// - Own primary address ORed with 40h makes the device a talker.
// - Secondary command group bytes never change the addressed state.
// - Unlisten returns a listener to listener idle.
// - Untalk returns a talker to talker idle.
// - Addressed command codes are 01h, 04h and 08h with ATN low.
// - Universal and unaddress codes are 11h, 14h, 18h, 19h, 3Fh and 5Fh.
// - The primary address is configurable from 0 to 30.
// - Every bus line is low-true: low means asserted or logic one.
`ifndef GBCD_DEFINES_SVH
`define GBCD_DEFINES_SVH

`define GBCD_CODE_GTL   8'h01
`define GBCD_CODE_SDC   8'h04
`define GBCD_CODE_GET   8'h08
`define GBCD_CODE_LLO   8'h11
`define GBCD_CODE_DCL   8'h14
`define GBCD_CODE_SPE   8'h18
`define GBCD_CODE_SPD   8'h19
`define GBCD_CODE_UNL   8'h3F
`define GBCD_CODE_UNT   8'h5F
`define GBCD_LAG_BASE   8'h20
`define GBCD_TAG_BASE   8'h40
`define GBCD_SCG_BASE   8'h60
`define GBCD_GROUP_MASK 8'h60
`define GBCD_ADDR_MASK  8'h1F
`define GBCD_BYTE_MASK  8'h7F
`define GBCD_RST_BYTE   8'h00

`endif

// ===== core/gbcd_pkg.sv
package gbcd_pkg;

  typedef enum {
    CMD_NONE,
    CMD_GTL,
    CMD_SDC,
    CMD_GET,
    CMD_LLO,
    CMD_DCL,
    CMD_SPE,
    CMD_SPD,
    CMD_UNL,
    CMD_UNT,
    CMD_MLA,
    CMD_MTA,
    CMD_OTA,
    CMD_SCG
  } gbcd_cmd_e;

  typedef logic [7:0] gbcd_byte_t;
  typedef logic [4:0] gbcd_addr_t;

endpackage : gbcd_pkg

// ===== core/gbcd_top.sv
`timescale 1ns/10ps
`include "gbcd_defines.svh"
module gbcd_top
  import gbcd_pkg::*;
#(
  parameter int DATA_W = 8
)(
  input  wire logic              SYS_CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              CE_I,
  input  wire logic              ATN_N_I,
  input  wire logic              IFC_N_I,
  input  wire logic              REN_N_I,
  input  wire logic              EOI_N_I,
  input  wire logic [DATA_W-1:0] DIO_N_I,
  input  wire logic              BYTE_STB_I,
  input  wire logic [4:0]        PRIMARY_ADDR_I,
  input  wire logic              LOCK_ON_REMOTE_I,
  input  wire logic              GTL_UNLOCK_I,
  input  wire logic              GET_UNADDR_I,
  input  wire logic              LOCAL_KEY_I,
  input  wire logic              SVC_REQ_I,
  input  wire logic              SVC_DONE_I,
  input  wire logic              TX_LAST_I,
  output logic                   SRQ_N_O,
  output logic                   SRQ_OE_O,
  output logic                   EOI_N_O,
  output logic                   EOI_OE_O,
  output logic                   LISTEN_O,
  output logic                   TALK_O,
  output logic                   REMOTE_O,
  output logic                   LOCKOUT_O,
  output logic                   PANEL_LOCK_O,
  output logic                   SPOLL_O,
  output logic                   DEV_CLEAR_O,
  output logic                   TRIGGER_O,
  output logic [DATA_W-1:0]      DATA_O,
  output logic                   DATA_VLD_O,
  output logic                   DATA_END_O
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // Command compares are eight bits wide; other widths cannot be decoded.
  if (DATA_W != 8) begin : g_bad_width
    $error("gbcd_top supports only DATA_W of 8");
  end

  // ****************************************************************
  // Bus line levels and command decode
  // ****************************************************************
  logic atn;
  logic ifc;
  logic ren;
  logic eoi;
  logic take;
  logic cmd_take;
  logic dat_take;
  gbcd_cmd_if cif ();

  assign atn      = ~ATN_N_I;
  assign ifc      = ~IFC_N_I;
  assign ren      = ~REN_N_I;
  assign eoi      = ~EOI_N_I;
  assign take     = BYTE_STB_I & CE_I;
  assign cmd_take = take & atn;
  assign dat_take = take & ~atn;
  assign cif.cmd_byte = ~DIO_N_I;
  assign cif.own_addr = PRIMARY_ADDR_I;

  gbcd_decode u_decode (
    .bus (cif.dec)
  );

  function automatic logic is_cmd(input gbcd_cmd_e c);
    is_cmd = cmd_take && (cif.cmd == c);
  endfunction : is_cmd

  // ****************************************************************
  // Interface state: addressing, serial poll, remote and lockout
  // ****************************************************************
  logic listen;
  logic talk;
  logic spoll;
  logic remote;
  logic lockout;
  logic panel;
  logic ren_q;
  logic next_listen;
  logic next_talk;
  logic next_spoll;
  logic next_remote;
  logic next_lockout;
  logic next_panel;
  logic gtl_hit;

  always_comb begin
    next_listen  = listen;
    next_talk    = talk;
    next_spoll   = spoll;
    next_remote  = remote;
    next_lockout = lockout;
    // Addressed commands see the listen state held before this byte.
    gtl_hit      = is_cmd(CMD_GTL) && listen;
    if (ifc) begin
      next_listen = 1'b0;
      next_talk   = 1'b0;
      next_spoll  = 1'b0;
    end else if (cmd_take) begin
      case (cif.cmd)
        CMD_MLA: next_listen = 1'b1;
        CMD_UNL: next_listen = 1'b0;
        CMD_MTA: next_talk   = 1'b1;
        CMD_OTA: next_talk   = 1'b0;
        CMD_UNT: next_talk   = 1'b0;
        CMD_SPE: next_spoll  = 1'b1;
        CMD_SPD: next_spoll  = 1'b0;
        default: next_listen = listen;
      endcase
    end
    if (!ren) begin
      next_remote  = 1'b0;
      next_lockout = 1'b0;
    end else begin
      if (gtl_hit) begin
        next_remote = 1'b0;
      end else if (!ren_q || is_cmd(CMD_MLA)) begin
        next_remote = 1'b1;
      end else if (LOCAL_KEY_I && CE_I && !lockout) begin
        next_remote = 1'b0;
      end
      if (is_cmd(CMD_LLO)) begin
        next_lockout = 1'b1;
      end else if (gtl_hit && GTL_UNLOCK_I) begin
        next_lockout = 1'b0;
      end
    end
    next_panel = next_lockout || (next_remote && LOCK_ON_REMOTE_I);
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      listen  <= 1'b0;
      talk    <= 1'b0;
      spoll   <= 1'b0;
      remote  <= 1'b0;
      lockout <= 1'b0;
      panel   <= 1'b0;
      ren_q   <= 1'b0;
    end else if (CE_I) begin
      listen  <= next_listen;
      talk    <= next_talk;
      spoll   <= next_spoll;
      remote  <= next_remote;
      lockout <= next_lockout;
      panel   <= next_panel;
      ren_q   <= ren;
    end
  end

  // ****************************************************************
  // Actions, service request and data path
  // ****************************************************************
  // While CE_I is low the action and data strobes hold their value too,
  // so the consumer must qualify them with the same enable.
  logic              clr;
  logic              trig;
  logic              srq;
  logic              eoi_drv;
  logic              dvld;
  logic              dend;
  gbcd_byte_t        dbyte;
  logic              next_clr;
  logic              next_trig;
  logic              next_srq;
  logic              next_eoi_drv;
  logic              next_dvld;
  logic              next_dend;
  gbcd_byte_t        next_dbyte;

  always_comb begin
    next_clr     = is_cmd(CMD_DCL) || (is_cmd(CMD_SDC) && listen);
    next_trig    = is_cmd(CMD_GET) && (listen || GET_UNADDR_I);
    // A new request wins over a clear or a done in the same cycle.
    next_srq     = (srq && !SVC_DONE_I && !next_clr) || SVC_REQ_I;
    next_eoi_drv = talk && !atn && TX_LAST_I;
    next_dvld    = dat_take && listen;
    next_dend    = dat_take && listen && eoi;
    next_dbyte   = next_dvld ? cif.cmd_byte : dbyte;
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      clr     <= 1'b0;
      trig    <= 1'b0;
      srq     <= 1'b0;
      eoi_drv <= 1'b0;
      dvld    <= 1'b0;
      dend    <= 1'b0;
      dbyte   <= `GBCD_RST_BYTE;
    end else if (CE_I) begin
      clr     <= next_clr;
      trig    <= next_trig;
      srq     <= next_srq;
      eoi_drv <= next_eoi_drv;
      dvld    <= next_dvld;
      dend    <= next_dend;
      dbyte   <= next_dbyte;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Open-drain lines: the level is always low and only the enable moves.
  assign SRQ_N_O      = 1'b0;
  assign SRQ_OE_O     = srq;
  assign EOI_N_O      = 1'b0;
  assign EOI_OE_O     = eoi_drv;
  assign LISTEN_O     = listen;
  assign TALK_O       = talk;
  assign REMOTE_O     = remote;
  assign LOCKOUT_O    = lockout;
  assign PANEL_LOCK_O = panel;
  assign SPOLL_O      = spoll;
  assign DEV_CLEAR_O  = clr;
  assign TRIGGER_O    = trig;
  assign DATA_O       = dbyte;
  assign DATA_VLD_O   = dvld;
  assign DATA_END_O   = dend;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // One idle cycle sits between the address and the command, as on a real bus.
  sequence s_listen_gtl;
    is_cmd(CMD_MLA) && !ifc ##1 !cmd_take && !ifc ##1 is_cmd(CMD_GTL) && !ifc;
  endsequence

  ifc_idle_a: assert property (CE_I && ifc |=> !LISTEN_O && !TALK_O)
    else $error("interface clear left an addressed state");
  own_listen_a: assert property (is_cmd(CMD_MLA) && !ifc |=> LISTEN_O)
    else $error("own listen address ignored");
  own_talk_a: assert property (is_cmd(CMD_MTA) && !ifc |=> TALK_O)
    else $error("own talk address ignored");
  unlisten_a: assert property (is_cmd(CMD_UNL) |=> !LISTEN_O)
    else $error("unlisten left listener active");
  untalk_a: assert property (is_cmd(CMD_UNT) |=> !TALK_O)
    else $error("untalk left talker active");
  other_talk_a: assert property (is_cmd(CMD_OTA) |=> !TALK_O)
    else $error("other talk address left talker active");
  scg_hold_a: assert property (is_cmd(CMD_SCG) && !ifc |=>
    $stable(LISTEN_O) && $stable(TALK_O))
    else $error("secondary byte changed addressing");
  llo_lock_a: assert property (is_cmd(CMD_LLO) && ren |=> LOCKOUT_O && PANEL_LOCK_O)
    else $error("local lockout not applied");
  ren_drop_a: assert property (CE_I && !ren |=> !REMOTE_O && !LOCKOUT_O)
    else $error("remote held without remote enable");
  dcl_clear_a: assert property (is_cmd(CMD_DCL) |=> DEV_CLEAR_O)
    else $error("device clear not issued");
  sdc_addr_a: assert property (is_cmd(CMD_SDC) && !LISTEN_O |=> !DEV_CLEAR_O)
    else $error("selective clear acted while unaddressed");
  gtl_local_a: assert property (s_listen_gtl |=> !REMOTE_O)
    else $error("go to local after own listen address kept remote");
  spoll_a: assert property (is_cmd(CMD_SPE) && !ifc |=> SPOLL_O ##0 (SPOLL_O || !CE_I)[*1])
    else $error("serial poll enable ignored");
  spd_a: assert property (is_cmd(CMD_SPD) |=> !SPOLL_O)
    else $error("serial poll disable ignored");
  srq_hold_a: assert property (SRQ_OE_O && !SVC_DONE_I && !next_clr |=> SRQ_OE_O)
    else $error("service request dropped before service");
  cmd_not_data_a: assert property (cmd_take |=> !DATA_VLD_O)
    else $error("command byte delivered as data");
  data_pass_a: assert property (dat_take && LISTEN_O |=>
    DATA_VLD_O && DATA_O == ~$past(DIO_N_I))
    else $error("data byte not delivered");
  data_refuse_a: assert property (dat_take && !LISTEN_O |=> !DATA_VLD_O)
    else $error("data byte delivered while not listening");
  data_end_a: assert property (dat_take && LISTEN_O && eoi |=> DATA_END_O)
    else $error("end of message not flagged");
  eoi_drive_a: assert property (CE_I && TALK_O && !atn && TX_LAST_I |=> EOI_OE_O)
    else $error("last byte sent without end mark");
  eoi_atn_a: assert property (CE_I && atn |=> !EOI_OE_O)
    else $error("end mark driven during a command byte");
  get_trig_a: assert property (is_cmd(CMD_GET) && (LISTEN_O || GET_UNADDR_I)
    |=> TRIGGER_O)
    else $error("trigger not started");
  get_refuse_a: assert property (is_cmd(CMD_GET) && !LISTEN_O && !GET_UNADDR_I
    |=> !TRIGGER_O)
    else $error("trigger started while unaddressed");
  sdc_clear_a: assert property (is_cmd(CMD_SDC) && LISTEN_O |=> DEV_CLEAR_O)
    else $error("selective clear ignored while addressed");
  srq_set_a: assert property (CE_I && SVC_REQ_I |=> SRQ_OE_O)
    else $error("service request not raised");
  lock_key_a: assert property (CE_I && ren && LOCKOUT_O && REMOTE_O
    && !is_cmd(CMD_GTL) |=> REMOTE_O)
    else $error("local key left remote under lockout");
  ren_enter_a: assert property (CE_I && ren && !ren_q && !is_cmd(CMD_GTL) |=> REMOTE_O)
    else $error("remote enable did not enter remote");
  lock_panel_a: assert property (LOCKOUT_O |-> PANEL_LOCK_O)
    else $error("lockout without panel lock");
  ifc_spoll_a: assert property (CE_I && ifc |=> !SPOLL_O)
    else $error("interface clear left serial poll active");

endmodule : gbcd_top

// ===== tb/gbcd_ctl_model.sv
`timescale 1ns/10ps
module gbcd_ctl_model
  import gbcd_pkg::*;
(
  input  wire logic clk_i,
  output gbcd_byte_t dio_n_o,
  output logic       atn_n_o,
  output logic       eoi_n_o,
  output logic       ifc_n_o,
  output logic       ren_n_o,
  output logic       stb_o
);
  // ************************************************************
  // Controller in charge
  // ************************************************************
  // Released lines read high, as the bus terminators pull them up.
  initial begin
    dio_n_o = 8'hFF;
    atn_n_o = 1'b1;
    eoi_n_o = 1'b1;
    ifc_n_o = 1'b1;
    ren_n_o = 1'b1;
    stb_o   = 1'b0;
  end

  // One byte per call; a free cycle always follows, so a strobe never merges.
  task automatic send_byte(input logic atn, input gbcd_byte_t val, input logic eoi);
    @(negedge clk_i);
    atn_n_o <= ~atn;
    dio_n_o <= ~val;
    eoi_n_o <= ~eoi;
    stb_o   <= 1'b1;
    @(negedge clk_i);
    atn_n_o <= 1'b1;
    dio_n_o <= 8'hFF;
    eoi_n_o <= 1'b1;
    stb_o   <= 1'b0;
  endtask : send_byte

  task automatic uniline(input logic ren, input logic ifc);
    @(negedge clk_i);
    ren_n_o <= ~ren;
    ifc_n_o <= ~ifc;
    @(negedge clk_i);
  endtask : uniline
endmodule : gbcd_ctl_model

// ===== tb/gpib_bus_command_decoder_tb.sv
`timescale 1ns/10ps
`include "gbcd_defines.svh"
module gpib_bus_command_decoder_tb
  import gbcd_pkg::*;
;
  localparam logic [7:0] f_lis = 8'h80, f_tlk = 8'h40, f_rem = 8'h20, f_lko = 8'h10;
  localparam logic [7:0] f_pnl = 8'h08, f_spl = 8'h04, f_clr = 8'h02, f_trg = 8'h01;
  localparam logic [7:0] f_vld = 8'h80, f_end = 8'h40, f_srq = 8'h20, f_eoi = 8'h10;
  localparam logic [7:0] no_rem = 8'hDF;
  localparam int         limit  = 3000;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       ce, lock_rem, gtl_unl, get_un, lkey, sreq, sdone, txl;
  logic [4:0] addr;
  gbcd_byte_t dio_n;
  logic       atn_n, eoi_n, ifc_n, ren_n, stb;
  logic       srq_n, srq_oe, eoi_n_out, eoi_oe, lis, tlk, rem, lko, pnl, spl, clr, trg;
  logic       vld, dend;
  gbcd_byte_t data;
  logic [7:0] st, io;
  int         checks = 0, n_fail = 0, cycles = 0;
  logic [4:0] addr_tab [3] = '{5'h00, 5'h10, 5'h1E};

  assign st = {lis, tlk, rem, lko, pnl, spl, clr, trg};
  assign io = {vld, dend, srq_oe, eoi_oe, 4'h0};

  always #50 sys_clk = ~sys_clk;

  gbcd_ctl_model ctl (.clk_i(sys_clk), .dio_n_o(dio_n), .atn_n_o(atn_n), .eoi_n_o(eoi_n),
                      .ifc_n_o(ifc_n), .ren_n_o(ren_n), .stb_o(stb));

  gbcd_top DUT (
    .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .CE_I(ce), .ATN_N_I(atn_n), .IFC_N_I(ifc_n),
    .REN_N_I(ren_n), .EOI_N_I(eoi_n), .DIO_N_I(dio_n), .BYTE_STB_I(stb),
    .PRIMARY_ADDR_I(addr), .LOCK_ON_REMOTE_I(lock_rem), .GTL_UNLOCK_I(gtl_unl),
    .GET_UNADDR_I(get_un), .LOCAL_KEY_I(lkey), .SVC_REQ_I(sreq), .SVC_DONE_I(sdone),
    .TX_LAST_I(txl), .SRQ_N_O(srq_n), .SRQ_OE_O(srq_oe), .EOI_N_O(eoi_n_out),
    .EOI_OE_O(eoi_oe), .LISTEN_O(lis), .TALK_O(tlk), .REMOTE_O(rem), .LOCKOUT_O(lko),
    .PANEL_LOCK_O(pnl), .SPOLL_O(spl), .DEV_CLEAR_O(clr), .TRIGGER_O(trg), .DATA_O(data),
    .DATA_VLD_O(vld), .DATA_END_O(dend));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // A hung handshake would otherwise leave the run waiting for ever.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == limit) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(negedge sys_clk);
  endtask : tick

  task automatic cmd(input gbcd_byte_t val);
    ctl.send_byte(1'b1, val, 1'b0);
  endtask : cmd

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  initial begin
    {ce, lock_rem, gtl_unl, get_un, lkey, sreq, sdone, txl} = 8'h A0;
    addr = 5'h05;
    repeat (4) tick();
    sys_rst = 1'b0;
    chk(st, 8'h00);
    chk(io, 8'h00);
    chk({6'h00, srq_n, eoi_n_out}, 8'h00);
    end_test("reset");
    ctl.uniline(1'b1, 1'b0);
    chk(st, f_rem);
    lock_rem = 1'b1;
    tick();
    chk(st, f_rem | f_pnl);
    lock_rem = 1'b0;
    tick();
    lkey = 1'b1;
    tick();
    lkey = 1'b0;
    chk(st, 8'h00);
    ce = 1'b0;
    cmd(8'h25);
    ce = 1'b1;
    chk(st, 8'h00);
    cmd(8'h25);
    chk(st, f_lis | f_rem);
    end_test("remote");
    ctl.send_byte(1'b0, 8'hA5, 1'b1);
    chk(io, f_vld | f_end);
    chk(data, 8'hA5);
    ctl.send_byte(1'b0, 8'h3C, 1'b0);
    chk(io, f_vld);
    chk(data, 8'h3C);
    cmd(`GBCD_CODE_SPE);
    chk(io, 8'h00);
    chk(st, f_lis | f_rem | f_spl);
    cmd(`GBCD_CODE_SPD);
    chk(st, f_lis | f_rem);
    end_test("data");
    cmd(`GBCD_CODE_SDC);
    chk(st, f_lis | f_rem | f_clr);
    tick();
    chk(st, f_lis | f_rem);
    cmd(`GBCD_CODE_GET);
    chk(st, f_lis | f_rem | f_trg);
    cmd(`GBCD_CODE_LLO);
    chk(st, f_lis | f_rem | f_lko | f_pnl);
    cmd(`GBCD_CODE_GTL);
    chk(st, f_lis);
    cmd(`GBCD_CODE_UNL);
    chk(st, 8'h00);
    end_test("addressed");
    cmd(`GBCD_CODE_SDC);
    chk(st, 8'h00);
    cmd(`GBCD_CODE_GET);
    chk(st, 8'h00);
    ctl.send_byte(1'b0, 8'h55, 1'b1);
    chk(io, 8'h00);
    get_un = 1'b1;
    cmd(`GBCD_CODE_GET);
    chk(st, f_trg);
    get_un = 1'b0;
    end_test("unaddressed");
    sreq = 1'b1;
    tick();
    sreq = 1'b0;
    repeat (3) tick();
    chk(io, f_srq);
    cmd(`GBCD_CODE_DCL);
    chk(st, f_clr);
    tick();
    chk(io, 8'h00);
    sreq = 1'b1;
    tick();
    sreq = 1'b0;
    chk(io, f_srq);
    sdone = 1'b1;
    tick();
    sdone = 1'b0;
    chk(io, 8'h00);
    end_test("service");
    cmd(8'h45);
    chk(st, f_tlk);
    txl = 1'b1;
    tick();
    txl = 1'b0;
    chk(io, f_eoi);
    cmd(8'h46);
    chk(st, 8'h00);
    cmd(8'h45);
    cmd(8'h65);
    chk(st, f_tlk);
    cmd(`GBCD_CODE_UNT);
    chk(st, 8'h00);
    cmd(8'h45);
    cmd(8'h25);
    cmd(`GBCD_CODE_SPE);
    chk(st & no_rem, f_lis | f_tlk | f_spl);
    ctl.uniline(1'b1, 1'b1);
    ctl.uniline(1'b1, 1'b0);
    chk(st & no_rem, 8'h00);
    end_test("talk");
    foreach (addr_tab[i]) begin
      addr = addr_tab[i];
      cmd({3'b001, addr_tab[i]});
      chk(st & no_rem, f_lis);
      cmd({3'b010, addr_tab[i]});
      chk(st & no_rem, f_lis | f_tlk);
      cmd(`GBCD_CODE_UNL);
      cmd(`GBCD_CODE_UNT);
      chk(st & no_rem, 8'h00);
    end
    gtl_unl = 1'b0;
    cmd(`GBCD_CODE_LLO);
    lkey = 1'b1;
    tick();
    lkey = 1'b0;
    chk(st, f_rem | f_lko | f_pnl);
    cmd({3'b001, addr});
    cmd(`GBCD_CODE_GTL);
    chk(st, f_lis | f_lko | f_pnl);
    cmd(`GBCD_CODE_UNL);
    ctl.uniline(1'b0, 1'b0);
    cmd(`GBCD_CODE_LLO);
    chk(st, 8'h00);
    end_test("address");
    stop_test();
  end

endmodule : gpib_bus_command_decoder_tb
